/* File: core/status_regs_pkg.sv */
/*
 * Package for the reader status and count register bank: offsets, field
 * positions, reset values and the event bundles carried between the
 * framing logic and the bank.
 * Assumes an 8-bit register port with a 6-bit address, one clock.
 */
package status_regs_pkg;
    localparam logic [5:0] OFS_ERR_WAKE_FLAGS = 6'h19;
    localparam logic [5:0] OFS_MAIN_IRQ       = 6'h17;
    localparam logic [5:0] OFS_FIFO_FILL      = 6'h1a;
    localparam logic [5:0] OFS_FIFO_STATUS2   = 6'h1b;
    localparam logic [5:0] OFS_COLLISION      = 6'h1c;
    localparam logic [5:0] OFS_TX_COUNT_HIGH  = 6'h1d;
    localparam logic [5:0] OFS_TX_COUNT_LOW   = 6'h1e;

    localparam int BIT_CRC    = 7;
    localparam int BIT_PAR    = 6;
    localparam int BIT_SOFT   = 5;
    localparam int BIT_HARD   = 4;
    localparam int BIT_WT     = 3;
    localparam int BIT_WAM    = 2;
    localparam int BIT_WPH    = 1;
    localparam int BIT_WCAP   = 0;

    localparam int BIT_UNF    = 6;
    localparam int BIT_OVR    = 5;
    localparam int BIT_NCP    = 4;
    localparam int BIT_LB_LO  = 1;
    localparam int BIT_NP     = 0;

    localparam int BIT_CBYTE_LO = 4;
    localparam int BIT_CBIT_LO  = 1;
    localparam int BIT_CPB      = 0;

    localparam logic [6:0] FIFO_DEPTH  = 7'h60;
    localparam logic [7:0] RESET_VALUE = 8'h00;

    typedef struct packed {
        logic crc_err;
        logic parity_err;
        logic soft_framing;
        logic hard_framing;
        logic wakeup_timeout;
        logic amplitude_delta;
        logic phase_delta;
        logic capacitance_delta;
    } err_event_type;

    typedef struct packed {
        logic       byte_push;
        logic       byte_pop;
        logic       clear;
        logic       last_incomplete;
        logic [2:0] last_bits;
        logic       last_parity_missing;
        logic       last_strobe;
    } fifo_event_type;

    typedef struct packed {
        logic       strobe;
        logic [3:0] full_bytes;
        logic [2:0] bits;
        logic       on_parity;
    } collision_type;
endpackage

/* File: core/reader_irq_fifo_status_regs.sv */
/*
 * Error/wake-up flags, FIFO fill count and status, collision position
 * report and transmit byte count registers of the reader.
 * Assumes the serial register port presents one-cycle read and write
 * strobes with address and data on clk_i, and that the framing, timer and
 * measurement logic deliver one-cycle event pulses on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module reader_irq_fifo_status_regs (
    input  wire logic                           clk_i,
    input  wire logic                           reset_n_i,
    input  wire logic                           set_default_i,
    input  wire logic                           reg_rd_i,
    input  wire logic                           reg_wr_i,
    input  wire logic [5:0]                     reg_addr_i,
    input  wire logic [7:0]                     reg_wdata_i,
    input  wire status_regs_pkg::err_event_type  err_event_i,
    input  wire logic                           wakeup_every_timeout_i,
    input  wire status_regs_pkg::fifo_event_type fifo_event_i,
    input  wire status_regs_pkg::collision_type  collision_i,
    input  wire logic                           anticollision_active_i,
    output logic [7:0]                          reg_rdata_o,
    output logic                                err_summary_o,
    output logic [6:0]                          fifo_fill_o,
    output logic                                fifo_full_o,
    output logic [12:0]                         tx_byte_count_o,
    output logic [2:0]                          tx_split_bits_o
);
    import status_regs_pkg::*;

    logic [7:0]  err_flags_reg,  err_flags_next;
    logic        err_summary_reg, err_summary_next;
    logic [6:0]  fill_reg,       fill_next;
    logic        unf_reg,        unf_next;
    logic        ovr_reg,        ovr_next;
    logic        full_reg,       full_next;
    logic        ncp_reg,        ncp_next;
    logic [2:0]  last_byte_bit_count_reg, last_byte_bit_count_next;
    logic        last_byte_parity_missing_reg, last_byte_parity_missing_next;
    logic [7:0]  coll_reg,       coll_next;
    logic        coll_seen_reg,  coll_seen_next;
    logic [7:0]  tx_high_reg,    tx_high_next;
    logic [7:0]  tx_low_reg,     tx_low_next;
    logic [7:0]  rdata_reg,      rdata_next;

    // Read side effects fire in the cycle the strobe is taken
    function automatic logic rd_hit(input logic [5:0] ofs);
        rd_hit = reg_rd_i && (reg_addr_i == ofs);
    endfunction

    function automatic logic wr_hit(input logic [5:0] ofs);
        wr_hit = reg_wr_i && (reg_addr_i == ofs);
    endfunction

    logic [7:0] err_set;
    logic       push_ok;
    logic       pop_ok;
    logic [7:0] fifo_status2_byte;

    always_comb begin
        err_set                    = '0;
        err_set[BIT_CRC]           = err_event_i.crc_err;
        err_set[BIT_PAR]           = err_event_i.parity_err;
        err_set[BIT_SOFT]          = err_event_i.soft_framing;
        // A last byte without parity counts as hard framing too
        err_set[BIT_HARD]          = err_event_i.hard_framing
                                     || (fifo_event_i.last_strobe
                                         && fifo_event_i.last_parity_missing);
        err_set[BIT_WT]            = err_event_i.wakeup_timeout
                                     && wakeup_every_timeout_i;
        err_set[BIT_WAM]           = err_event_i.amplitude_delta;
        err_set[BIT_WPH]           = err_event_i.phase_delta;
        err_set[BIT_WCAP]          = err_event_i.capacitance_delta;
    end

    // Error flags: a new event in a main-interrupt read cycle survives that clear, but not a set-default
    always_comb begin
        err_flags_next   = err_flags_reg;
        err_summary_next = err_summary_reg;
        if (set_default_i) begin
            err_flags_next   = RESET_VALUE;
            err_summary_next = 1'b0;
        end else begin
            if (rd_hit(OFS_MAIN_IRQ)) begin
                err_flags_next = RESET_VALUE;
            end
            // Summary drops only when the detail flags are read or on set-default
            if (rd_hit(OFS_ERR_WAKE_FLAGS)) begin
                err_summary_next = 1'b0;
            end
            err_flags_next = err_flags_next | err_set;
            if (|err_set) begin
                err_summary_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            err_flags_reg   <= 8'h00;
            err_summary_reg <= 1'b0;
        end else begin
            err_flags_reg   <= err_flags_next;
            err_summary_reg <= err_summary_next;
        end
    end

    // FIFO fill count and status
    always_comb begin
        pop_ok     = fifo_event_i.byte_pop && (fill_reg != 7'h00);
        // A pop in the same cycle frees a slot, so a push at full is still taken
        push_ok    = fifo_event_i.byte_push && ((fill_reg != FIFO_DEPTH) || pop_ok);
        fill_next  = fill_reg;
        unf_next   = unf_reg;
        ovr_next   = ovr_reg;
        ncp_next   = ncp_reg;
        last_byte_bit_count_next      = last_byte_bit_count_reg;
        last_byte_parity_missing_next = last_byte_parity_missing_reg;
        // Set-default and a FIFO clear both empty the count and drop the status
        if (set_default_i || fifo_event_i.clear) begin
            fill_next = 7'h00;
            unf_next  = 1'b0;
            ovr_next  = 1'b0;
            ncp_next  = 1'b0;
            last_byte_bit_count_next      = 3'h0;
            last_byte_parity_missing_next = 1'b0;
        end else begin
            if (push_ok && !pop_ok) begin
                fill_next = fill_reg + 7'h01;
            end else if (pop_ok && !push_ok) begin
                fill_next = fill_reg - 7'h01;
            end
            if (rd_hit(OFS_FIFO_STATUS2)) begin
                ncp_next = 1'b0;
                last_byte_bit_count_next      = 3'h0;
                last_byte_parity_missing_next = 1'b0;
            end
            if (fifo_event_i.last_strobe) begin
                ncp_next = fifo_event_i.last_incomplete;
                last_byte_bit_count_next      = fifo_event_i.last_incomplete
                                                ? fifo_event_i.last_bits : 3'h0;
                last_byte_parity_missing_next = fifo_event_i.last_parity_missing;
            end
            // The parity flag survives emptying; a status read clears it and a new last byte reloads it
            if (fill_next == 7'h00) begin
                ncp_next = 1'b0;
                last_byte_bit_count_next = 3'h0;
            end
        end
        // Underflow and overflow still latch when a FIFO clear lands in the same cycle
        if (!set_default_i) begin
            if (fifo_event_i.byte_pop && !pop_ok) begin
                unf_next = 1'b1;
            end
            if (fifo_event_i.byte_push && !push_ok) begin
                ovr_next = 1'b1;
            end
        end
        // Full is kept in a flop so the output needs no decode after the register
        full_next = (fill_next == FIFO_DEPTH);
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fill_reg <= 7'h00;
            unf_reg  <= 1'b0;
            ovr_reg  <= 1'b0;
            ncp_reg  <= 1'b0;
            last_byte_bit_count_reg      <= 3'h0;
            last_byte_parity_missing_reg <= 1'b0;
            full_reg <= 1'b0;
        end else begin
            fill_reg <= fill_next;
            full_reg <= full_next;
            unf_reg  <= unf_next;
            ovr_reg  <= ovr_next;
            ncp_reg  <= ncp_next;
            last_byte_bit_count_reg      <= last_byte_bit_count_next;
            last_byte_parity_missing_reg <= last_byte_parity_missing_next;
        end
    end

    // Collision position: first collision of a frame wins
    always_comb begin
        coll_next      = coll_reg;
        coll_seen_next = coll_seen_reg;
        if (set_default_i) begin
            coll_next      = RESET_VALUE;
            coll_seen_next = 1'b0;
        // Outside anticollision the first-collision latch re-arms
        end else if (!anticollision_active_i) begin
            coll_seen_next = 1'b0;
        end else if (collision_i.strobe && !coll_seen_reg) begin
            coll_next[7:BIT_CBYTE_LO]          = collision_i.full_bytes;
            coll_next[3:BIT_CBIT_LO]           = collision_i.bits;
            coll_next[BIT_CPB]                 = collision_i.on_parity;
            coll_seen_next                     = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            coll_reg      <= 8'h00;
            coll_seen_reg <= 1'b0;
        end else begin
            coll_reg      <= coll_next;
            coll_seen_reg <= coll_seen_next;
        end
    end

    // Transmit byte count, writable by the host
    always_comb begin
        tx_high_next = tx_high_reg;
        tx_low_next  = tx_low_reg;
        if (set_default_i) begin
            tx_high_next = RESET_VALUE;
            tx_low_next  = RESET_VALUE;
        end else begin
            if (wr_hit(OFS_TX_COUNT_HIGH)) begin
                tx_high_next = reg_wdata_i;
            end
            if (wr_hit(OFS_TX_COUNT_LOW)) begin
                tx_low_next = reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_high_reg <= 8'h00;
            tx_low_reg  <= 8'h00;
        end else begin
            tx_high_reg <= tx_high_next;
            tx_low_reg  <= tx_low_next;
        end
    end

    // Read data, registered: valid the cycle after the read strobe
    always_comb begin
        fifo_status2_byte            = '0;
        fifo_status2_byte[BIT_UNF]   = unf_reg;
        fifo_status2_byte[BIT_OVR]   = ovr_reg;
        fifo_status2_byte[BIT_NCP]   = ncp_reg;
        fifo_status2_byte[3:BIT_LB_LO] = last_byte_bit_count_reg;
        fifo_status2_byte[BIT_NP]    = last_byte_parity_missing_reg;
        rdata_next = rdata_reg;
        if (reg_rd_i) begin
            // The main interrupt register is only watched here and reads as zero
            case (reg_addr_i)
                OFS_ERR_WAKE_FLAGS: rdata_next = err_flags_reg;
                OFS_FIFO_FILL:      rdata_next = {1'b0, fill_reg};
                OFS_FIFO_STATUS2:   rdata_next = fifo_status2_byte;
                OFS_COLLISION:      rdata_next = coll_reg;
                OFS_TX_COUNT_HIGH:  rdata_next = tx_high_reg;
                OFS_TX_COUNT_LOW:   rdata_next = tx_low_reg;
                default:            rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o     = rdata_reg;
    assign err_summary_o   = err_summary_reg;
    assign fifo_fill_o     = fill_reg;
    assign fifo_full_o     = full_reg;
    assign tx_byte_count_o = {tx_high_reg, tx_low_reg[7:3]};
    assign tx_split_bits_o = tx_low_reg[2:0];
endmodule

`default_nettype wire

/* File: dv/status_regs_chk.sv */
/* Port checker for the status register bank.
   Assumes it is bound to the bank and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module status_regs_chk
    import status_regs_pkg::*;
(
    input wire logic           clk_i,
    input wire logic           reset_n_i,
    input wire logic           set_default_i,
    input wire logic           reg_rd_i,
    input wire logic           reg_wr_i,
    input wire logic [5:0]     reg_addr_i,
    input wire logic [7:0]     reg_wdata_i,
    input wire err_event_type  err_event_i,
    input wire logic           wakeup_every_timeout_i,
    input wire fifo_event_type fifo_event_i,
    input wire collision_type  collision_i,
    input wire logic           anticollision_active_i,
    input wire logic [7:0]     reg_rdata_o,
    input wire logic           err_summary_o,
    input wire logic [6:0]     fifo_fill_o,
    input wire logic           fifo_full_o,
    input wire logic [12:0]    tx_byte_count_o,
    input wire logic [2:0]     tx_split_bits_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic quiet;
    assign quiet = !fifo_event_i.byte_push && !fifo_event_i.byte_pop && !fifo_event_i.clear;

    rdata_unmapped_a: assert property (reg_rd_i && (reg_addr_i < 6'h19 || reg_addr_i > 6'h1e)
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd_i && !set_default_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    fill_range_a: assert property (fifo_fill_o <= FIFO_DEPTH) else $error("fill above depth");
    full_decode_a: assert property (fifo_full_o == (fifo_fill_o == FIFO_DEPTH))
        else $error("full flag wrong");
    push_count_a: assert property (fifo_event_i.byte_push && !fifo_event_i.byte_pop
        && !fifo_event_i.clear && !set_default_i && !fifo_full_o
        |=> fifo_fill_o == $past(fifo_fill_o) + 7'h01) else $error("push did not count");
    push_full_a: assert property (fifo_event_i.byte_push && !fifo_event_i.byte_pop
        && !fifo_event_i.clear && !set_default_i && fifo_full_o
        |=> fifo_full_o && fifo_fill_o == FIFO_DEPTH) else $error("push into full fifo counted");
    pop_empty_a: assert property (fifo_event_i.byte_pop && !fifo_event_i.byte_push
        && fifo_fill_o == 7'h00 |=> fifo_fill_o == 7'h00) else $error("empty pop moved count");
    fill_read_a: assert property (reg_rd_i && reg_addr_i == OFS_FIFO_FILL && quiet
        && !set_default_i |=> reg_rdata_o == {1'b0, $past(fifo_fill_o)})
        else $error("fill read wrong");
    summary_set_a: assert property (err_event_i.crc_err && !set_default_i |=> err_summary_o)
        else $error("summary not raised");
    default_clr_a: assert property (set_default_i && err_event_i == 8'h00 && quiet
        && !reg_wr_i |=> fifo_fill_o == 7'h00 && tx_byte_count_o == 13'h0000 && !err_summary_o)
        else $error("set default left state");
    tx_high_a: assert property (reg_wr_i && reg_addr_i == OFS_TX_COUNT_HIGH
        && !set_default_i |=> tx_byte_count_o[12:5] == $past(reg_wdata_i))
        else $error("tx high wrong");
    tx_low_a: assert property (reg_wr_i && reg_addr_i == OFS_TX_COUNT_LOW
        && !set_default_i |=> {tx_byte_count_o[4:0], tx_split_bits_o} == $past(reg_wdata_i))
        else $error("tx low wrong");
endmodule
bind reader_irq_fifo_status_regs status_regs_chk u_chk (.*);
`default_nettype wire

/* File: dv/host_model.sv */
/* Host microcontroller model driving the register port.
   Assumes one-cycle strobes and read data one edge after the read edge. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic            rd_o,
    output logic            wr_o,
    output logic [5:0]      addr_o,
    output logic [7:0]      wdata_o
);
    initial begin
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 6'h00;
        wdata_o = 8'h00;
    end
    // Idle address and data are inverted so stale values are never reused
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] wd, output logic [7:0] d);
        @(posedge clk_i);
        #1 rd_o = !w;
        wr_o = w;
        addr_o = a;
        wdata_o = wd;
        @(posedge clk_i);
        #1 rd_o = 1'b0;
        wr_o = 1'b0;
        d = rdata_i;
        addr_o = ~a;
        wdata_o = ~wd;
    endtask
endmodule
`default_nettype wire

/* File: dv/tb_reader_irq_fifo_status_regs.sv */
/* Self-checking bench for the status register bank.
   Assumes the host model and checker files are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb_reader_irq_fifo_status_regs;
    import status_regs_pkg::*;
    logic clk_i, reset_n_i, sd, rd, wr, wk, ac, sum, full;
    logic [5:0] addr;
    logic [7:0] wd, rdata, d;
    logic [6:0] fill;
    logic [12:0] txc;
    logic [2:0] txs;
    err_event_type ee;
    fifo_event_type fe;
    collision_type co;
    int fail_count = 0;
    int num_checks = 0;

    reader_irq_fifo_status_regs DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .set_default_i(sd),
        .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wd), .err_event_i(ee),
        .wakeup_every_timeout_i(wk), .fifo_event_i(fe), .collision_i(co),
        .anticollision_active_i(ac), .reg_rdata_o(rdata), .err_summary_o(sum),
        .fifo_fill_o(fill), .fifo_full_o(full), .tx_byte_count_o(txc), .tx_split_bits_o(txs));
    host_model host (.clk_i(clk_i), .rdata_i(rdata), .rd_o(rd), .wr_o(wr), .addr_o(addr),
        .wdata_o(wd));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        host.xfer(1'b0, a, 8'h00, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic fev(input fifo_event_type f, input int n);
        @(posedge clk_i);
        #1 fe = f;
        repeat (n) @(posedge clk_i);
        #1 fe = '0;
    endtask
    task automatic eev(input err_event_type e);
        @(posedge clk_i);
        #1 ee = e;
        @(posedge clk_i);
        #1 ee = '0;
    endtask
    task automatic t_zero;
        for (int a = 'h19; a <= 'h1e; a++) rdc(6'(a), 8'h00);
    endtask
    task automatic t_err;
        wk = 1'b1;
        for (int i = 0; i < 8; i++) begin
            eev(err_event_type'(8'h01 << i));
            chk("summary", 13'h1, sum);
            rdc(OFS_ERR_WAKE_FLAGS, 8'h01 << i);
            rdc(OFS_ERR_WAKE_FLAGS, 8'h01 << i);
            chk("summary", 13'h0, sum);
            rdc(OFS_MAIN_IRQ, 8'h00);
            rdc(OFS_ERR_WAKE_FLAGS, 8'h00);
        end
        wk = 1'b0;
        eev(err_event_type'(8'h08));
        rdc(OFS_ERR_WAKE_FLAGS, 8'h00);
    endtask
    task automatic t_fifo;
        fev(9'h100, 96);
        rdc(OFS_FIFO_FILL, 8'h60);
        chk("full", 13'h1, full);
        fev(9'h100, 1);
        rdc(OFS_FIFO_FILL, 8'h60);
        rdc(OFS_FIFO_STATUS2, 8'h20);
        rdc(OFS_FIFO_STATUS2, 8'h20);
        fev(9'h080, 97);
        rdc(OFS_FIFO_FILL, 8'h00);
        rdc(OFS_FIFO_STATUS2, 8'h60);
        fev(9'h040, 1);
        rdc(OFS_FIFO_STATUS2, 8'h00);
    endtask
    task automatic t_last;
        fev(9'h100, 2);
        fev(9'h037, 1);
        rdc(OFS_FIFO_FILL, 8'h02);
        rdc(OFS_FIFO_STATUS2, 8'h1b);
        rdc(OFS_ERR_WAKE_FLAGS, 8'h10);
        rdc(OFS_FIFO_STATUS2, 8'h00);
        fev(9'h037, 1);
        fev(9'h080, 2);
        rdc(OFS_FIFO_STATUS2, 8'h01);
        rdc(OFS_MAIN_IRQ, 8'h00);
    endtask
    task automatic t_coll;
        ac = 1'b1;
        @(posedge clk_i);
        #1 co = 9'h13b;
        @(posedge clk_i);
        #1 co = 9'h1a4;
        @(posedge clk_i);
        #1 co = '0;
        rdc(OFS_COLLISION, 8'h3b);
        ac = 1'b0;
    endtask
    task automatic t_tx;
        host.xfer(1'b1, OFS_TX_COUNT_HIGH, 8'hff, d);
        host.xfer(1'b1, OFS_TX_COUNT_LOW, 8'hfd, d);
        chk("tx count", 13'h1fff, txc);
        chk("tx split", 13'h5, txs);
        rdc(OFS_TX_COUNT_HIGH, 8'hff);
        rdc(OFS_TX_COUNT_LOW, 8'hfd);
        host.xfer(1'b1, OFS_COLLISION, 8'h55, d);
        rdc(OFS_COLLISION, 8'h3b);
        rdc(6'h3f, 8'h00);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        reset_n_i = 1'b0;
        {sd, wk, ac} = 3'b000;
        ee = '0;
        fe = '0;
        co = '0;
        repeat (2) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        t_zero();
        t_err();
        t_fifo();
        t_last();
        t_coll();
        t_tx();
        @(posedge clk_i);
        #1 sd = 1'b1;
        @(posedge clk_i);
        #1 sd = 1'b0;
        t_zero();
        test_done();
    end

    initial begin
        #100000;
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
